//--- verification/hbfsc_host_model.sv
// Serial host model: frames MSB first with a 48 ns shift clock that idles low
module hbfsc_host_model (
   // Link
   output logic      sclk_o,
   output logic      chip_select_n_o,
   output logic      si_o,
   input  wire logic so_i
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] status_word;
   logic        pre_bit;

   // Select starts low for a moment so the device sees a clean rising edge
   initial begin
      sclk_o          = 1'b0;
      chip_select_n_o = 1'b0;
      si_o            = 1'b0;
      status_word     = 16'h0000;
      pre_bit         = 1'b0;
      #1 chip_select_n_o = 1'b1;
   end

   // Sends n bits; the last 16 bits seen after rising edges are kept
   task automatic frame(input logic [31:0] data, input int n);
      // SI stays low until the pre-bit is read, else it would be ORed in
      chip_select_n_o = 1'b0;
      #2 pre_bit = so_i;
      // Clock starts late so the device has frozen its status word
      for (int i = n - 1; i >= 0; i--) begin
         si_o = data[i];
         #22 sclk_o = 1'b1;
         #2 status_word = {status_word[14:0], so_i};
         #22 sclk_o = 1'b0;
         #2;
      end
      si_o = 1'b0;
      #24 chip_select_n_o = 1'b1;
      #40;
   endtask
endmodule

//--- verification/tb_top.sv
// Bench for the half-bridge fault and status controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int HOLD = 20;
   // Rows: command, pulse inputs, expected high and low switches
   localparam logic [29:0] ROWS [6] = '{
      {16'h1fab, 2'h0, 6'h15, 6'h2a}, {16'h1fd5, 2'h0, 6'h2a, 6'h15},
      {16'h02ff, 2'h0, 6'h05, 6'h00}, {16'h0002, 2'h1, 6'h01, 6'h00},
      {16'h0000, 2'h2, 6'h00, 6'h02}, {16'h0000, 2'h0, 6'h00, 6'h00}};

   logic       clock_i, reset_n_i, enable_i, uv, ov, tw, sclk, cs_n, si, so, so_oe;
   logic [1:0] pulse;
   logic [5:0] tsd, oc, ul, hs, ls;
   int         fail_count, check_count;

   hbfsc_top #(.HOLDOFF_CYCLES(HOLD)) uut (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
      .chip_select_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
      .enable_i(enable_i), .external_pulse_input_i(pulse),
      .supply_undervoltage_i(uv), .supply_overvoltage_i(ov),
      .thermal_warning_i(tw), .thermal_shutdown_i(tsd), .overcurrent_i(oc),
      .underload_i(ul), .high_side_switch_o(hs), .low_side_switch_o(ls));

   hbfsc_host_model host (.sclk_o(sclk), .chip_select_n_o(cs_n), .si_o(si), .so_i(so));

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic sw(input logic [5:0] h, l);
      check({4'h0, hs, ls}, {4'h0, h, l}, "switches");
   endtask

   // Frame latency plus the side-change gap fits well inside 16 cycles
   task automatic send(input logic [15:0] c);
      // Lets fault inputs reach the status word before the frame freezes it
      repeat (8) @(negedge clock_i);
      host.frame({16'h0000, c}, 16);
      repeat (16) @(posedge clock_i);
      @(negedge clock_i);
   endtask

   function automatic logic [15:0] stat(input logic [5:0] on);
      stat = 16'h0000;
      for (int c = 0; c < 6; c++) stat[2*c+1 +: 2] = {2{on[c]}};
   endfunction

   // Shoot-through would destroy the bridge, so every cycle is watched
   always @(negedge clock_i) begin
      if (reset_n_i === 1'b1 && (hs & ls) !== 6'h00) begin
         fail_count++;
         $display("mismatch at %0t: both sides on", $time);
      end
   end

   initial begin
      repeat (100000) @(posedge clock_i);
      fail_count++;
      $display("mismatch at %0t: run did not finish", $time);
      tally_and_finish;
   end

   initial begin
      // Reset falls just after time zero so the link-side flops see its edge
      reset_n_i = 1'b1;
      enable_i = 1'b1;
      {uv, ov, tw} = 3'h0;
      pulse = 2'h0;
      {tsd, oc, ul} = 18'h0;
      #1 reset_n_i = 1'b0;
      repeat (5) @(posedge clock_i);
      check({so_oe, hs, ls}, 16'h0000, "reset outputs");
      repeat (5) @(posedge clock_i);
      reset_n_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      for (int r = 0; r < 6; r++) begin
         @(posedge clock_i) pulse <= ROWS[r][13:12];
         send(ROWS[r][29:14]);
         check(host.pre_bit, 1'b0, "pre-bit");
         sw(ROWS[r][11:6], ROWS[r][5:0]);
         if (ROWS[r][13:12] == 2'h0) begin
            send(ROWS[r][29:14]);
            check(host.status_word, stat(ROWS[r][11:6] | ROWS[r][5:0]), "status");
         end
      end
      $display("test table done");
      send(16'h1fab);
      @(posedge clock_i) tsd <= 6'h04;
      @(posedge clock_i) tsd <= 6'h00;
      send(16'h1fab);
      check(host.pre_bit, 1'b1, "thermal pre-bit");
      sw(6'h11, 6'h2a);
      send(16'h9fab);
      sw(6'h15, 6'h2a);
      send(16'h1fab);
      check(host.pre_bit, 1'b0, "pre-bit cleared");
      $display("test thermal done");
      @(posedge clock_i) oc <= 6'h02;
      send(16'h1fab);
      sw(6'h15, 6'h28);
      check(host.status_word, 16'h9fee, "overcurrent status");
      send(16'h9fab);
      sw(6'h15, 6'h28);
      @(posedge clock_i) oc <= 6'h00;
      repeat (HOLD) @(posedge clock_i);
      send(16'h9fab);
      sw(6'h15, 6'h2a);
      $display("test overcurrent done");
      @(posedge clock_i) uv <= 1'b1;
      send(16'h1fd5);
      sw(6'h00, 6'h00);
      send(16'h1fd5);
      check(host.status_word[14], 1'b1, "supply fail set");
      @(posedge clock_i) uv <= 1'b0;
      send(16'h1fd5);
      sw(6'h2a, 6'h15);
      check(host.status_word[14], 1'b0, "supply fail auto clear");
      @(posedge clock_i) ov <= 1'b1;
      send(16'h1fd5);
      sw(6'h00, 6'h00);
      send(16'h1fd4);
      sw(6'h2a, 6'h15);
      @(posedge clock_i) ov <= 1'b0;
      $display("test supply done");
      @(posedge clock_i) ul <= 6'h01;
      send(16'h1fd4);
      send(16'h1fd4);
      sw(6'h2a, 6'h15);
      check(host.status_word[13], 1'b1, "underload flag");
      send(16'h3fd4);
      sw(6'h2a, 6'h14);
      @(posedge clock_i) ul <= 6'h00;
      repeat (HOLD) @(posedge clock_i);
      send(16'h9fd4);
      @(posedge clock_i) tw <= 1'b1;
      send(16'h1fd4);
      send(16'h1fd4);
      check(host.status_word, stat(6'h3f) | 16'h0001, "warning status");
      sw(6'h2a, 6'h15);
      @(posedge clock_i) tw <= 1'b0;
      send(16'h1fd4);
      send(16'h1fd4);
      check(host.status_word[0], 1'b0, "warning auto clear");
      $display("test underload and warning done");
      host.frame(32'h00000000, 15);
      repeat (16) @(negedge clock_i);
      sw(6'h2a, 6'h15);
      send(16'h1fd4);
      sw(6'h2a, 6'h15);
      host.frame(32'h00ff1fab, 24);
      repeat (16) @(posedge clock_i);
      sw(6'h15, 6'h2a);
      $display("test frame length done");
      // A latched fault must also be wiped by the enable toggle
      @(posedge clock_i) oc <= 6'h01;
      @(posedge clock_i) oc <= 6'h00;
      repeat (8) @(posedge clock_i);
      @(posedge clock_i) enable_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      sw(6'h00, 6'h00);
      send(16'h1fd5);
      sw(6'h00, 6'h00);
      @(posedge clock_i) enable_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      sw(6'h00, 6'h00);
      send(16'h0000);
      send(16'h0000);
      check(host.status_word, 16'h0000, "status after enable");
      $display("test enable done");
      tally_and_finish;
   end
endmodule

//--- verilog/hbfsc_chan.sv
// One half-bridge channel: high/low side drive with non-overlap gap
module hbfsc_chan (
   // System
   input  wire logic clock_i,
   input  wire logic reset_n_i,
   // Request
   input  wire logic drive_on_i,
   input  wire logic high_side_i,
   // Switches
   output logic      high_side_switch_o,
   output logic      low_side_switch_o
);

   logic [3:0] gap_cnt_reg;
   logic       want_hs;
   logic       want_ls;

   assign want_hs = drive_on_i & high_side_i;
   assign want_ls = drive_on_i & ~high_side_i;

   // Any change first passes through both-off, then waits out the gap
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         high_side_switch_o <= 1'b0;
         low_side_switch_o  <= 1'b0;
         gap_cnt_reg        <= 4'h0;
      end else if ({want_hs, want_ls} == {high_side_switch_o, low_side_switch_o}) begin
         if (gap_cnt_reg != 4'h0) begin
            gap_cnt_reg <= gap_cnt_reg - 4'h1;
         end
      end else if (high_side_switch_o | low_side_switch_o) begin
         high_side_switch_o <= 1'b0; // [RULE7]
         low_side_switch_o  <= 1'b0;
         gap_cnt_reg        <= hbfsc_pkg::NONOVERLAP_LOAD; // [RULE7]
      end else if (gap_cnt_reg != 4'h0) begin
         gap_cnt_reg <= gap_cnt_reg - 4'h1;
      end else begin
         high_side_switch_o <= want_hs; // [RULE8]
         low_side_switch_o  <= want_ls;
      end
   end

   a_no_shoot_through: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !(high_side_switch_o && low_side_switch_o)) // [RULE7]
      else $error("both switches of one channel on");

   a_gap_after_high: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $fell(high_side_switch_o) |-> !low_side_switch_o [*5]) // [RULE7]
      else $error("low side on within non-overlap gap");

   a_gap_after_low: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      $fell(low_side_switch_o) |-> !high_side_switch_o [*5]) // [RULE7]
      else $error("high side on within non-overlap gap");

endmodule

//--- verilog/hbfsc_pkg.sv
// Shared constants and carrier types of the half-bridge fault and status controller
package hbfsc_pkg;

   localparam int NUM_CH          = 6;
   localparam int PWM_CH          = 2;
   localparam int WORD_W          = 16;
   localparam int HOLDOFF_W       = 16;

   // Clock rate and timing figures
   localparam int CLK_MHZ         = 250;
   localparam int NONOVERLAP_NS   = 20;
   localparam int NONOVERLAP_CYC  = (NONOVERLAP_NS * CLK_MHZ + 999) / 1000;
   localparam int SRR_HOLDOFF_NS  = 10000;
   localparam int SRR_HOLDOFF_CYC = (SRR_HOLDOFF_NS * CLK_MHZ + 999) / 1000;

   // Frame bit counter: 16 first, then steps of 8
   localparam logic [4:0] FRAME_FIRST = 5'h10;
   localparam logic [4:0] FRAME_WRAP  = 5'h17;
   localparam logic [4:0] FRAME_ONE   = 5'h01;

   // Per-channel output status codes
   localparam logic [1:0] CODE_OFF = 2'h0;
   localparam logic [1:0] CODE_OCS = 2'h1;
   localparam logic [1:0] CODE_ULD = 2'h2;
   localparam logic [1:0] CODE_ON  = 2'h3;

   typedef struct packed {
      logic                 status_reset_request;
      logic                 spare;
      logic                 underload_shutdown_enable;
      logic [NUM_CH-1:0]    channel_enable_bit;
      logic [NUM_CH-1:0]    channel_side_select;
      logic                 overvoltage_lockout_enable;
   } hbfsc_cmd_t;

   typedef struct packed {
      logic                    overcurrent_flag;
      logic                    supply_fail_flag;
      logic                    underload_flag;
      logic [NUM_CH-1:0][1:0]  output_status_code;
      logic                    thermal_warning_flag;
   } hbfsc_status_t;

   typedef struct packed {
      logic              cs_n;
      logic              en;
      logic [PWM_CH-1:0] pulse;
      logic              uv;
      logic              ov;
      logic              tw;
      logic [NUM_CH-1:0] tsd;
      logic [NUM_CH-1:0] oc;
      logic [NUM_CH-1:0] ul;
      logic              frame_tgl;
   } hbfsc_pins_t;

   localparam hbfsc_cmd_t    CMD_RST    = '0;
   localparam hbfsc_status_t STATUS_RST = '0;
   localparam hbfsc_pins_t   PINS_RST   = '{cs_n: 1'b1, default: '0};
   localparam logic [3:0]    NONOVERLAP_LOAD = NONOVERLAP_CYC[3:0];

endpackage

//--- verilog/hbfsc_top.sv
// Fault, status and serial control logic of a six-channel half-bridge driver

// Summary of operation
// RULE1 - Pre-frame output is thermal latch ORed input
// RULE2 - Host idles select high, data, clock low
// RULE3 - Pre-bit until first rising clock edge
// RULE4 - Reset zeroes registers, outputs stay off
// RULE5 - Operate only after reset, enable high
// RULE6 - Supply lockout floats outputs, keeps registers
// RULE7 - Never both sides on; insert gap
// RULE8 - Drivers stay on until command or fault
// RULE9 - Channels 1,2 driven by enable or pulse
// RULE10 - Host sets side bit, clears enable
// RULE11 - Thermal, overcurrent faults latch off outputs
// RULE12 - Supply lockout auto-recovers, status not latched
// RULE13 - Configuration writes accepted during lockout
// RULE14 - Warning and codes only report
// RULE15 - Status frozen during frame, updated after
// RULE16 - Host resends previous pattern when polling
// RULE17 - Reset request clears all status memory
// RULE18 - Reset request at frame end, hold-off
// RULE19 - Persisting fault re-engages protection
// RULE20 - Enable toggle and reset clear status
// RULE21 - Host reads each status word
// RULE22 - Valid frame loads last 16 bits
// RULE23 - Underload shuts off only when enabled
// RULE24 - Pulse inputs synchronised, same gap control
// RULE25 - Hold-off duration is a parameter
module hbfsc_top #(
   parameter int unsigned HOLDOFF_CYCLES = hbfsc_pkg::SRR_HOLDOFF_CYC // [RULE25]
) (
   // System
   input  wire logic                           clock_i,
   input  wire logic                           reset_n_i,
   // Serial link
   input  wire logic                           sclk_i,
   input  wire logic                           chip_select_n_i,
   input  wire logic                           si_i,
   output logic                                so_o,
   output logic                                so_oe_o,
   // Device control
   input  wire logic                           enable_i,
   input  wire logic [hbfsc_pkg::PWM_CH-1:0]   external_pulse_input_i,
   // Fault monitors
   input  wire logic                           supply_undervoltage_i,
   input  wire logic                           supply_overvoltage_i,
   input  wire logic                           thermal_warning_i,
   input  wire logic [hbfsc_pkg::NUM_CH-1:0]   thermal_shutdown_i,
   input  wire logic [hbfsc_pkg::NUM_CH-1:0]   overcurrent_i,
   input  wire logic [hbfsc_pkg::NUM_CH-1:0]   underload_i,
   // Bridge switches
   output logic [hbfsc_pkg::NUM_CH-1:0]        high_side_switch_o,
   output logic [hbfsc_pkg::NUM_CH-1:0]        low_side_switch_o
);

   localparam logic [hbfsc_pkg::HOLDOFF_W-1:0] HOLDOFF_LOAD =
      HOLDOFF_CYCLES[hbfsc_pkg::HOLDOFF_W-1:0];

   // Link domain state
   logic [hbfsc_pkg::WORD_W-1:0]        shift_reg;
   logic [4:0]                          bit_cnt_reg;
   logic                                first_seen_reg;
   logic                                frame_tgl_reg;
   logic                                so_bit_reg;

   // Core domain state
   hbfsc_pkg::hbfsc_pins_t              pins_raw;
   hbfsc_pkg::hbfsc_pins_t              pins_meta_reg;
   hbfsc_pkg::hbfsc_pins_t              pins_reg;
   hbfsc_pkg::hbfsc_cmd_t               cmd_reg;
   hbfsc_pkg::hbfsc_cmd_t               frame_word;
   hbfsc_pkg::hbfsc_status_t            status_live;
   hbfsc_pkg::hbfsc_status_t            status_rep_reg;
   logic                                cs_prev_reg;
   logic                                tgl_seen_reg;
   logic                                operating_reg;
   logic                                tsd_any_reg;
   logic [hbfsc_pkg::HOLDOFF_W-1:0]     holdoff_cnt_reg;
   logic [hbfsc_pkg::NUM_CH-1:0]        tsd_lat_reg;
   logic [hbfsc_pkg::NUM_CH-1:0]        ocs_lat_reg;
   logic [hbfsc_pkg::NUM_CH-1:0]        uld_lat_reg;
   logic [hbfsc_pkg::NUM_CH-1:0]        req_on;
   logic [hbfsc_pkg::NUM_CH-1:0]        shut_vec;
   logic [hbfsc_pkg::NUM_CH-1:0]        drive_on;
   logic [hbfsc_pkg::NUM_CH-1:0][1:0]   code_live;
   logic                                frame_end;
   logic                                frame_ok;
   logic                                srr_exec;
   logic                                lockout;
   logic                                clr;

   // ---------------- Link clock domain ----------------
   // Cleared by the select pin itself since the shift clock stands still between frames
   always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         first_seen_reg <= 1'b0;
      end else begin
         first_seen_reg <= 1'b1; // [RULE3]
      end
   end

   // One register serves as command input and daisy-chain delay line
   always_ff @(posedge sclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shift_reg     <= 16'h0000;
         bit_cnt_reg   <= 5'h00;
         frame_tgl_reg <= 1'b0;
         so_bit_reg    <= 1'b0;
      end else if (!first_seen_reg) begin
         shift_reg     <= {status_rep_reg[14:0], si_i};
         so_bit_reg    <= status_rep_reg[15]; // [RULE3]
         bit_cnt_reg   <= hbfsc_pkg::FRAME_ONE;
         frame_tgl_reg <= ~frame_tgl_reg;
      end else begin
         shift_reg   <= {shift_reg[14:0], si_i};
         so_bit_reg  <= shift_reg[15];
         bit_cnt_reg <= (bit_cnt_reg == hbfsc_pkg::FRAME_WRAP) ?
                        hbfsc_pkg::FRAME_FIRST : bit_cnt_reg + 5'h01; // [RULE22]
      end
   end

   // The pre-bit path must follow the chained input without a clock edge
   assign so_o    = first_seen_reg ? so_bit_reg : (tsd_any_reg | si_i); // [RULE1] [RULE2]
   assign so_oe_o = ~chip_select_n_i & operating_reg; // [RULE4] [RULE5]

   // ---------------- Core clock domain ----------------
   assign pins_raw = '{cs_n:      chip_select_n_i,
                       en:        enable_i,
                       pulse:     external_pulse_input_i,
                       uv:        supply_undervoltage_i,
                       ov:        supply_overvoltage_i,
                       tw:        thermal_warning_i,
                       tsd:       thermal_shutdown_i,
                       oc:        overcurrent_i,
                       ul:        underload_i,
                       frame_tgl: frame_tgl_reg};

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         pins_meta_reg <= hbfsc_pkg::PINS_RST;
         pins_reg      <= hbfsc_pkg::PINS_RST;
      end else begin
         pins_meta_reg <= pins_raw;
         pins_reg      <= pins_meta_reg; // [RULE24]
      end
   end

   // Shift word and count are quiet once select has risen; the synchronised
   // select edge plus the frame toggle act as the handshake for reading them
   assign frame_end  = pins_reg.cs_n & ~cs_prev_reg;
   assign frame_word = hbfsc_pkg::hbfsc_cmd_t'(shift_reg);
   assign frame_ok   = frame_end & operating_reg & (pins_reg.frame_tgl != tgl_seen_reg)
                       & (bit_cnt_reg == hbfsc_pkg::FRAME_FIRST); // [RULE22] [RULE5]
   assign srr_exec   = frame_ok & frame_word.status_reset_request
                       & (holdoff_cnt_reg == 16'h0000); // [RULE18]
   assign clr        = srr_exec; // [RULE17]

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         cs_prev_reg   <= 1'b1;
         tgl_seen_reg  <= 1'b0;
         operating_reg <= 1'b0;
      end else begin
         cs_prev_reg   <= pins_reg.cs_n;
         operating_reg <= pins_reg.en; // [RULE5]
         if (frame_end) begin
            tgl_seen_reg <= pins_reg.frame_tgl;
         end
      end
   end

   // Command register; loads even in lockout so new settings apply on recovery
   always_ff @(posedge clock_i) begin
      if (!reset_n_i || !pins_reg.en) begin
         cmd_reg <= hbfsc_pkg::CMD_RST; // [RULE4] [RULE20]
      end else if (frame_ok) begin
         cmd_reg                      <= frame_word; // [RULE13] [RULE16] [RULE22]
         cmd_reg.status_reset_request <= 1'b0;
      end
   end

   // Hold-off after an executed reset request; requests inside it are dropped
   always_ff @(posedge clock_i) begin
      if (!reset_n_i || !pins_reg.en) begin
         holdoff_cnt_reg <= 16'h0000;
      end else if (srr_exec) begin
         holdoff_cnt_reg <= HOLDOFF_LOAD; // [RULE18]
      end else if (holdoff_cnt_reg != 16'h0000) begin
         holdoff_cnt_reg <= holdoff_cnt_reg - 16'h0001;
      end
   end

   // Latched fault memory; a fault still present wins over the clear
   always_ff @(posedge clock_i) begin
      if (!reset_n_i || !pins_reg.en) begin
         tsd_lat_reg <= 6'h00; // [RULE20]
         ocs_lat_reg <= 6'h00;
         uld_lat_reg <= 6'h00;
      end else begin
         tsd_lat_reg <= (tsd_lat_reg & ~{hbfsc_pkg::NUM_CH{clr}}) | pins_reg.tsd; // [RULE11] [RULE19]
         ocs_lat_reg <= (ocs_lat_reg & ~{hbfsc_pkg::NUM_CH{clr}}) | pins_reg.oc; // [RULE11] [RULE19]
         // Underload cannot be reported over a standing overcurrent
         uld_lat_reg <= (uld_lat_reg & ~{hbfsc_pkg::NUM_CH{clr}})
                        | (pins_reg.ul & ~ocs_lat_reg); // [RULE19]
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         tsd_any_reg <= 1'b0;
      end else begin
         tsd_any_reg <= |tsd_lat_reg; // [RULE1]
      end
   end

   // Drive decision
   assign lockout  = pins_reg.uv | (pins_reg.ov & cmd_reg.overvoltage_lockout_enable); // [RULE6] [RULE12]
   assign shut_vec = tsd_lat_reg | ocs_lat_reg
                     | (uld_lat_reg & {hbfsc_pkg::NUM_CH{cmd_reg.underload_shutdown_enable}}); // [RULE11] [RULE23]
   assign req_on   = cmd_reg.channel_enable_bit
                     | {{(hbfsc_pkg::NUM_CH - hbfsc_pkg::PWM_CH){1'b0}}, pins_reg.pulse}; // [RULE9] [RULE24]
   // Thermal warning deliberately has no term here
   assign drive_on = req_on & ~shut_vec
                     & {hbfsc_pkg::NUM_CH{operating_reg & pins_reg.en & ~lockout}}; // [RULE8] [RULE14]

   genvar g;
   generate
      for (g = 0; g < hbfsc_pkg::NUM_CH; g++) begin : g_chan
         hbfsc_chan u_chan (
            .clock_i            (clock_i),
            .reset_n_i          (reset_n_i),
            .drive_on_i         (drive_on[g]),
            .high_side_i        (cmd_reg.channel_side_select[g]), // [RULE9]
            .high_side_switch_o (high_side_switch_o[g]),
            .low_side_switch_o  (low_side_switch_o[g])
         );
         assign code_live[g] = ocs_lat_reg[g] ? hbfsc_pkg::CODE_OCS :
                               uld_lat_reg[g] ? hbfsc_pkg::CODE_ULD :
                               (high_side_switch_o[g] | low_side_switch_o[g]) ?
                               hbfsc_pkg::CODE_ON : hbfsc_pkg::CODE_OFF; // [RULE14]
      end
   endgenerate

   always_comb begin
      status_live                      = hbfsc_pkg::STATUS_RST;
      status_live.overcurrent_flag     = |ocs_lat_reg;
      status_live.supply_fail_flag     = pins_reg.uv | pins_reg.ov; // [RULE12]
      status_live.underload_flag       = |uld_lat_reg;
      status_live.output_status_code   = code_live;
      status_live.thermal_warning_flag = pins_reg.tw; // [RULE14]
   end

   // Reported status: frozen while select is low, read by the link domain then
   always_ff @(posedge clock_i) begin
      if (!reset_n_i || !pins_reg.en) begin
         status_rep_reg <= hbfsc_pkg::STATUS_RST; // [RULE4] [RULE20]
      end else if (srr_exec) begin
         status_rep_reg <= hbfsc_pkg::STATUS_RST; // [RULE17]
      end else if (pins_reg.cs_n) begin
         status_rep_reg <= status_live; // [RULE15]
      end
   end

   // ---------------- Checks ----------------
   a_cmd_load_valid: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE22]
      frame_ok |=> (cmd_reg[14:0] == $past(shift_reg[14:0])))
      else $error("valid frame not loaded");

   a_cmd_keep_bad: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE22]
      (frame_end && !frame_ok && pins_reg.en) |=> $stable(cmd_reg))
      else $error("invalid frame changed command");

   a_status_frozen: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE15]
      (!pins_reg.cs_n && pins_reg.en) |=> $stable(status_rep_reg))
      else $error("status changed during frame");

   a_lockout_off: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE6]
      pins_reg.uv |=> (high_side_switch_o == 6'h00 && low_side_switch_o == 6'h00))
      else $error("outputs on during undervoltage");

   a_enable_clears: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE20]
      !pins_reg.en |=> (status_rep_reg == hbfsc_pkg::STATUS_RST
                        && cmd_reg == hbfsc_pkg::CMD_RST))
      else $error("enable low did not clear registers");

   a_srr_clears_ocs: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE17]
      (srr_exec && pins_reg.oc == 6'h00 && pins_reg.en) |=> (ocs_lat_reg == 6'h00))
      else $error("reset request left overcurrent latched");

   a_srr_reengage: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE19]
      (srr_exec && pins_reg.oc[0] && pins_reg.en) |=> ocs_lat_reg[0])
      else $error("persisting overcurrent not re-latched");

   a_holdoff_start: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE18]
      (srr_exec && pins_reg.en) |=> (holdoff_cnt_reg == HOLDOFF_LOAD))
      else $error("hold-off timer not started");

   a_pulse_drive: assert property (@(posedge clock_i) disable iff (!reset_n_i) // [RULE9]
      (pins_reg.pulse[0] && cmd_reg.channel_side_select[0] && drive_on[0]) [*8]
      |=> high_side_switch_o[0])
      else $error("pulse input did not drive channel 1 high side");

   c_frame_loaded: cover property (@(posedge clock_i) disable iff (!reset_n_i) frame_ok);
   c_srr_done: cover property (@(posedge clock_i) disable iff (!reset_n_i) srr_exec);
   c_lockout_seen: cover property (@(posedge clock_i) disable iff (!reset_n_i)
      lockout && cmd_reg.channel_enable_bit != 6'h00);

endmodule
